// ---- hw/hssc_top.sv ----
// Hot-swap signalling control: enumeration output, removal LED, ejector
// switch sampling, with an AXI4-Lite register slave and one interrupt.
// Assumes ejector_switch_in is asynchronous (high = handle closed) and the
// enumeration pin is open drain, resolved outside from its enable.
// Functional notes
// - Pull enumeration pin low while a flag is set and mask is clear.
// - In normal operation the LED follows the LED-on control bit.
// - After reset keep LED on until preload done and handle closed.
// - Switch sets extract flag, inserted flag only after preload done; CSR never shows raw switch.
// - Current switch level readable in bit 8 of misc control register.
//
// The AXI4-Lite slave port and the address map were left to the implementer.
`default_nettype none
module hssc_top
  import hssc_pkg::*;
(
  input  wire logic        ref_clk,          // 100 MHz clock
  input  wire logic        rst_n,            // Async reset, active low
  input  wire logic [7:0]  s_axi_awaddr,     // Write address
  input  wire logic        s_axi_awvalid,    // Write address valid
  output logic             s_axi_awready,    // Write address ready
  input  wire logic [31:0] s_axi_wdata,      // Write data
  input  wire logic [3:0]  s_axi_wstrb,      // Write strobes
  input  wire logic        s_axi_wvalid,     // Write data valid
  output logic             s_axi_wready,     // Write data ready
  output logic [1:0]       s_axi_bresp,      // Write response
  output logic             s_axi_bvalid,     // Write response valid
  input  wire logic        s_axi_bready,     // Write response ready
  input  wire logic [7:0]  s_axi_araddr,     // Read address
  input  wire logic        s_axi_arvalid,    // Read address valid
  output logic             s_axi_arready,    // Read address ready
  output logic [31:0]      s_axi_rdata,      // Read data
  output logic [1:0]       s_axi_rresp,      // Read response
  output logic             s_axi_rvalid,     // Read data valid
  input  wire logic        s_axi_rready,     // Read data ready
  input  wire logic        ejector_switch_in, // Handle switch, 1 = closed
  output logic             enum_signal_out,  // Open-drain pin output level
  output logic             enum_signal_oe,   // High while pulling low
  output logic             removal_led_out,  // Removal LED, 1 = on
  output logic             irq_out           // Level interrupt
);

  // Switch synchroniser
  logic sw_meta_r;
  logic sw_sync_r;
  logic sw_prev_r;
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      sw_meta_r <= 1'b0;
      sw_sync_r <= 1'b0;
      sw_prev_r <= 1'b0;
    end else begin
      sw_meta_r <= ejector_switch_in;
      sw_sync_r <= sw_meta_r;
      sw_prev_r <= sw_sync_r;
    end
  end

  wire sw_close = sw_sync_r & ~sw_prev_r;
  wire sw_open  = ~sw_sync_r & sw_prev_r;

  // Control and status state
  logic                inserted_flag_r;
  logic                extract_flag_r;
  logic                led_on_ctl_r;
  logic                enum_irq_mask_r;
  logic                preload_done_r;
  logic                reset_hold_r;
  logic [HSSC_EV_W-1:0] ev_sts_r;
  logic [HSSC_EV_W-1:0] ev_mask_r;

  // AXI write channel state
  logic        aw_got_r;
  logic        w_got_r;
  logic [7:0]  aw_addr_r;
  logic [31:0] w_data_r;
  logic [3:0]  w_strb_r;

  wire aw_hs   = s_axi_awvalid & s_axi_awready;
  wire w_hs    = s_axi_wvalid & s_axi_wready;
  wire wr_go   = aw_got_r & w_got_r & ~s_axi_bvalid;
  wire wr_csr  = wr_go & (aw_addr_r == HSSC_CSR_ADDR);
  wire wr_irq  = wr_go & (aw_addr_r == HSSC_IRQ_ADDR);
  wire wr_mask = wr_go & (aw_addr_r == HSSC_MASK_ADDR);
  wire wr_pre  = wr_go & (aw_addr_r == HSSC_PRE_ADDR);
  wire wr_map  = wr_csr | wr_irq | wr_mask | wr_pre |
                 (wr_go & (aw_addr_r == HSSC_MISC_ADDR));
  wire b0      = w_strb_r[0];

  // Flag events and software clears (write one), set wins
  wire set_ins = sw_close & preload_done_r;
  wire set_ext = sw_open;
  wire clr_ins = wr_csr & b0 & w_data_r[HSSC_INS_BIT];
  wire clr_ext = wr_csr & b0 & w_data_r[HSSC_EXT_BIT];
  wire [HSSC_EV_W-1:0] ev_set = {set_ext, set_ins};
  wire [HSSC_EV_W-1:0] ev_clr = (wr_irq & b0) ?
                                w_data_r[HSSC_EV_W-1:0] : '0;

  wire ins_nxt  = set_ins | (inserted_flag_r & ~clr_ins);
  wire ext_nxt  = set_ext | (extract_flag_r & ~clr_ext);
  wire hold_nxt = reset_hold_r & ~(preload_done_r & sw_sync_r);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      inserted_flag_r <= 1'b0;
      extract_flag_r  <= 1'b0;
      led_on_ctl_r    <= HSSC_LED_RST;
      enum_irq_mask_r <= HSSC_EIM_RST;
      preload_done_r  <= 1'b0;
      reset_hold_r    <= 1'b1;
      ev_sts_r        <= '0;
      ev_mask_r       <= HSSC_MASK_RST;
    end else begin
      inserted_flag_r <= ins_nxt;
      extract_flag_r  <= ext_nxt;
      reset_hold_r    <= hold_nxt;
      ev_sts_r        <= ev_set | (ev_sts_r & ~ev_clr);
      if (wr_csr && b0) begin
        led_on_ctl_r    <= w_data_r[HSSC_LED_BIT];
        enum_irq_mask_r <= w_data_r[HSSC_EIM_BIT];
      end
      if (wr_mask && b0) begin
        ev_mask_r <= w_data_r[HSSC_EV_W-1:0];
      end
      if (wr_pre && b0 && w_data_r[0]) begin
        preload_done_r <= 1'b1;
      end
    end
  end

  // Pin outputs, registered
  wire enum_drive = (inserted_flag_r | extract_flag_r) &
                    ~enum_irq_mask_r;
  wire led_nxt    = reset_hold_r | led_on_ctl_r;
  wire irq_nxt    = |(ev_sts_r & ev_mask_r);

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      enum_signal_out <= 1'b1;
      enum_signal_oe  <= 1'b0;
      removal_led_out <= 1'b1;
      irq_out         <= 1'b0;
    end else begin
      enum_signal_out <= ~enum_drive;
      enum_signal_oe  <= enum_drive;
      removal_led_out <= led_nxt;
      irq_out         <= irq_nxt;
    end
  end

  // Write channel handshake
  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      aw_got_r      <= 1'b0;
      w_got_r       <= 1'b0;
      aw_addr_r     <= 8'h00;
      w_data_r      <= 32'h0000_0000;
      w_strb_r      <= 4'h0;
      s_axi_awready <= 1'b1;
      s_axi_wready  <= 1'b1;
      s_axi_bvalid  <= 1'b0;
      s_axi_bresp   <= HSSC_RESP_OK;
    end else begin
      if (aw_hs) begin
        aw_got_r      <= 1'b1;
        aw_addr_r     <= s_axi_awaddr;
        s_axi_awready <= 1'b0;
      end
      if (w_hs) begin
        w_got_r      <= 1'b1;
        w_data_r     <= s_axi_wdata;
        w_strb_r     <= s_axi_wstrb;
        s_axi_wready <= 1'b0;
      end
      if (wr_go) begin
        aw_got_r     <= 1'b0;
        w_got_r      <= 1'b0;
        s_axi_bvalid <= 1'b1;
        s_axi_bresp  <= wr_map ? HSSC_RESP_OK : HSSC_RESP_ERR;
      end
      if (s_axi_bvalid && s_axi_bready) begin
        s_axi_bvalid  <= 1'b0;
        s_axi_awready <= 1'b1;
        s_axi_wready  <= 1'b1;
      end
    end
  end

  // Read path; raw switch only in misc register
  logic [31:0] csr_rd;
  logic [31:0] misc_rd;
  always_comb begin
    csr_rd = 32'h0000_0000;
    csr_rd[HSSC_INS_BIT] = inserted_flag_r;
    csr_rd[HSSC_EXT_BIT] = extract_flag_r;
    csr_rd[HSSC_LED_BIT] = led_on_ctl_r;
    csr_rd[HSSC_EIM_BIT] = enum_irq_mask_r;
    misc_rd = 32'h0000_0000;
    misc_rd[HSSC_SWS_BIT] = sw_sync_r;
  end

  wire [31:0] ev_rd   = {{(32-HSSC_EV_W){1'b0}}, ev_sts_r};
  wire [31:0] mask_rd = {{(32-HSSC_EV_W){1'b0}}, ev_mask_r};
  wire [31:0] pre_rd  = {31'h0000_0000, preload_done_r};
  wire rd_csr  = s_axi_araddr == HSSC_CSR_ADDR;
  wire rd_misc = s_axi_araddr == HSSC_MISC_ADDR;
  wire rd_ev   = s_axi_araddr == HSSC_IRQ_ADDR;
  wire rd_mask = s_axi_araddr == HSSC_MASK_ADDR;
  wire rd_pre  = s_axi_araddr == HSSC_PRE_ADDR;
  wire rd_map  = rd_csr | rd_misc | rd_ev | rd_mask | rd_pre;
  wire [31:0] rd_mux = rd_csr  ? csr_rd  :
                       rd_misc ? misc_rd :
                       rd_ev   ? ev_rd   :
                       rd_mask ? mask_rd :
                       rd_pre  ? pre_rd  : 32'h0000_0000;
  wire ar_hs = s_axi_arvalid & s_axi_arready;

  always_ff @(posedge ref_clk or negedge rst_n) begin
    if (!rst_n) begin
      s_axi_arready <= 1'b1;
      s_axi_rvalid  <= 1'b0;
      s_axi_rdata   <= 32'h0000_0000;
      s_axi_rresp   <= HSSC_RESP_OK;
    end else if (ar_hs) begin
      s_axi_arready <= 1'b0;
      s_axi_rvalid  <= 1'b1;
      s_axi_rdata   <= rd_mux;
      s_axi_rresp   <= rd_map ? HSSC_RESP_OK : HSSC_RESP_ERR;
    end else if (s_axi_rvalid && s_axi_rready) begin
      s_axi_rvalid  <= 1'b0;
      s_axi_arready <= 1'b1;
    end
  end

endmodule : hssc_top
`default_nettype wire

// ---- include/hssc_pkg.sv ----
// Package of the hot-swap signalling block: register map and field layout.
// Assumes a 32-bit AXI4-Lite slave with word-aligned registers.
`default_nettype none
package hssc_pkg;
  // Register byte addresses
  localparam logic [7:0] HSSC_CSR_ADDR  = 8'h00; // Hot-swap control/status
  localparam logic [7:0] HSSC_MISC_ADDR = 8'h04; // Miscellaneous control
  localparam logic [7:0] HSSC_IRQ_ADDR  = 8'h08; // Event status, W1C
  localparam logic [7:0] HSSC_MASK_ADDR = 8'h0C; // Event interrupt mask
  localparam logic [7:0] HSSC_PRE_ADDR  = 8'h10; // Preload done, write 1
  // Hot-swap control/status fields
  localparam int HSSC_INS_BIT  = 7;
  localparam int HSSC_EXT_BIT  = 6;
  localparam int HSSC_LED_BIT  = 3;
  localparam int HSSC_EIM_BIT  = 1;
  // Miscellaneous control field
  localparam int HSSC_SWS_BIT  = 8;
  // Event status / mask fields
  localparam int HSSC_EV_INS   = 0;
  localparam int HSSC_EV_EXT   = 1;
  localparam int HSSC_EV_W     = 2;
  // Values after reset
  localparam logic       HSSC_LED_RST  = 1'b0;
  localparam logic       HSSC_EIM_RST  = 1'b0;
  localparam logic [1:0] HSSC_MASK_RST = 2'h0;
  // AXI responses
  localparam logic [1:0] HSSC_RESP_OK  = 2'h0;
  localparam logic [1:0] HSSC_RESP_ERR = 2'h2;
endpackage : hssc_pkg
`default_nettype wire

// ---- sim/hssc_checker.sv ----
// Port checker of the hot-swap signalling block.
// Assumes a bind to hssc_top and writes that offer address and data together.
`default_nettype none
module hssc_checker (
  input wire logic        ref_clk,           // Clock
  input wire logic        rst_n,             // Reset
  input wire logic [7:0]  s_axi_awaddr,      // AW address
  input wire logic        s_axi_awvalid,     // AW valid
  input wire logic        s_axi_awready,     // AW ready
  input wire logic [31:0] s_axi_wdata,       // W data
  input wire logic [3:0]  s_axi_wstrb,       // W strobes
  input wire logic        s_axi_wvalid,      // W valid
  input wire logic [7:0]  s_axi_araddr,      // AR address
  input wire logic        s_axi_arvalid,     // AR valid
  input wire logic        s_axi_arready,     // AR ready
  input wire logic [31:0] s_axi_rdata,       // R data
  input wire logic        ejector_switch_in, // Switch
  input wire logic        enum_signal_out,   // Pin level
  input wire logic        enum_signal_oe,    // Pin enable
  input wire logic        removal_led_out    // LED
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge ref_clk); endclocking
  default disable iff (!rst_n);
  wire logic rd_csr = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h00;
  wire logic rd_misc = s_axi_arvalid && s_axi_arready && s_axi_araddr == 8'h04;
  wire logic led_wr = s_axi_awvalid && s_axi_awready && s_axi_wvalid &&
                      s_axi_awaddr == 8'h00 && s_axi_wstrb[0] && s_axi_wdata[3];
  pin_level_a: assert property (enum_signal_oe != enum_signal_out)
    else $error("enum pin level and enable disagree");
  // Read data and pin enable both reflect the flags of the AR edge
  enum_drive_a: assert property (rd_csr |=>
    enum_signal_oe == ((s_axi_rdata[7] | s_axi_rdata[6]) & ~s_axi_rdata[1]))
    else $error("enum pin drive disagrees with flags");
  led_ctl_a: assert property (led_wr |-> ##[1:3] removal_led_out)
    else $error("LED not on after control write");
  led_reset_a: assert property ($rose(rst_n) |-> removal_led_out)
    else $error("LED off right after reset");
  csr_raw_a: assert property (rd_csr |-> ##1
    (s_axi_rdata & 32'hFFFF_FF35) == 32'h0000_0000)
    else $error("unused control bits read nonzero");
  switch_sts_a: assert property (rd_misc &&
    $stable(ejector_switch_in) &&
    ejector_switch_in == $past(ejector_switch_in, 4)
    |-> ##1 s_axi_rdata[8] == ejector_switch_in)
    else $error("switch status bit wrong");
  flag_sticky_a: assert property ($fell(enum_signal_oe) |->
    $past(s_axi_awvalid) || $past(s_axi_awvalid, 2) || $past(s_axi_awvalid, 3))
    else $error("enum pin released without a write");
  pull_c: cover property ($rose(enum_signal_oe));
  led_c: cover property (led_wr);
  sts_c: cover property (rd_misc ##1 s_axi_rdata[8]);
endmodule : hssc_checker
bind hssc_top hssc_checker u_chk (.ref_clk, .rst_n, .s_axi_awaddr,
  .s_axi_awvalid, .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid,
  .s_axi_araddr, .s_axi_arvalid, .s_axi_arready, .s_axi_rdata,
  .ejector_switch_in, .enum_signal_out, .enum_signal_oe, .removal_led_out);
`default_nettype wire

// ---- sim/hssc_board.sv ----
// Board model: ejector handle switch and the pulled-up enumeration line.
// Assumes the bench moves the handle through handle_closed.
`default_nettype none
module hssc_board (
  input  wire logic handle_closed,     // Handle position, 1 = closed
  input  wire logic enum_signal_oe,    // Pin enable from the block
  output logic      ejector_switch_in, // Switch level to the block
  output logic      enum_pin           // Resolved line
);
  timeunit 1ns;
  timeprecision 1ps;
  // Line idles high through its pull-up
  assign enum_pin = enum_signal_oe ? 1'b0 : 1'b1;
  assign ejector_switch_in = handle_closed;
endmodule : hssc_board
`default_nettype wire

// ---- sim/hssc_top_tb.sv ----
// Self-checking bench of the hot-swap signalling block.
// Assumes the board model; register map from hssc_pkg.
`default_nettype none
module hssc_top_tb import hssc_pkg::*;;
  timeunit 1ns;
  timeprecision 1ps;
  typedef struct {bit w; logic [7:0] a; logic [31:0] d, e; logic [1:0] r;}
    hssc_row_s;
  logic        ref_clk = 1'b0, rst_n = 1'b0, closed = 1'b0, enum_pin;
  logic [7:0]  s_axi_awaddr = 8'h00, s_axi_araddr = 8'h00;
  logic [31:0] s_axi_wdata = 32'h0, s_axi_rdata, got;
  logic [3:0]  s_axi_wstrb = 4'hF;
  logic        s_axi_awvalid = 1'b0, s_axi_wvalid = 1'b0, s_axi_bready = 1'b0;
  logic        s_axi_arvalid = 1'b0, s_axi_rready = 1'b0, s_axi_bvalid;
  logic        s_axi_awready, s_axi_wready, s_axi_arready, s_axi_rvalid;
  logic        ejector_switch_in, enum_signal_out, enum_signal_oe;
  logic        removal_led_out, irq_out;
  logic [1:0]  s_axi_bresp, s_axi_rresp, resp;
  int          bad_count = 0, compares = 0;
  hssc_row_s   rows [7] = '{
    '{1'b0, HSSC_CSR_ADDR, 32'h0, 32'h0, HSSC_RESP_OK},
    '{1'b0, HSSC_MASK_ADDR, 32'h0, 32'h0, HSSC_RESP_OK},
    '{1'b0, HSSC_PRE_ADDR, 32'h0, 32'h0, HSSC_RESP_OK},
    '{1'b1, HSSC_MASK_ADDR, 32'h3, 32'h0, HSSC_RESP_OK},
    '{1'b0, HSSC_MASK_ADDR, 32'h0, 32'h3, HSSC_RESP_OK},
    '{1'b1, 8'h14, 32'hFFFF_FFFF, 32'h0, HSSC_RESP_ERR},
    '{1'b0, 8'h14, 32'h0, 32'h0, HSSC_RESP_ERR}};
  always #5 ref_clk = ~ref_clk;
  hssc_top u_dut (.ref_clk, .rst_n, .s_axi_awaddr, .s_axi_awvalid,
    .s_axi_awready, .s_axi_wdata, .s_axi_wstrb, .s_axi_wvalid, .s_axi_wready,
    .s_axi_bresp, .s_axi_bvalid, .s_axi_bready, .s_axi_araddr, .s_axi_arvalid,
    .s_axi_arready, .s_axi_rdata, .s_axi_rresp, .s_axi_rvalid, .s_axi_rready,
    .ejector_switch_in, .enum_signal_out, .enum_signal_oe, .removal_led_out,
    .irq_out);
  hssc_board u_board (.handle_closed(closed), .enum_signal_oe,
    .ejector_switch_in, .enum_pin);
  task automatic chk(input logic [31:0] g, input logic [31:0] e);
    compares++;
    if (g !== e) begin
      bad_count++;
      $display("unexpected at %0t: got %h want %h", $time, g, e);
    end
  endtask : chk
  // One write or one read; each channel is released on its own handshake
  task automatic bus(input bit w, input logic [7:0] a, input logic [31:0] d);
    bit ap;
    bit wp;
    ap = 1'b1;
    wp = w;
    @(posedge ref_clk);
    s_axi_awaddr  <= a;
    s_axi_araddr  <= a;
    s_axi_wdata   <= d;
    s_axi_awvalid <= w;
    s_axi_wvalid  <= w;
    s_axi_arvalid <= !w;
    s_axi_bready  <= w;
    s_axi_rready  <= !w;
    while (ap || wp) begin
      @(posedge ref_clk);
      if (ap && (w ? s_axi_awready : s_axi_arready)) begin
        ap = 1'b0;
        s_axi_awvalid <= 1'b0;
        s_axi_arvalid <= 1'b0;
      end
      if (wp && s_axi_wready) begin
        wp = 1'b0;
        s_axi_wvalid <= 1'b0;
      end
    end
    while (!(w ? s_axi_bvalid : s_axi_rvalid)) @(posedge ref_clk);
    got = s_axi_rdata;
    resp = w ? s_axi_bresp : s_axi_rresp;
    s_axi_bready <= 1'b0;
    s_axi_rready <= 1'b0;
  endtask : bus
  task automatic results();
    $display("compares %0d bad_count %0d", compares, bad_count);
    if (bad_count == 0 && compares > 0) $display("NO MISMATCHES");
    else $display("MISMATCHES SEEN");
    $finish;
  endtask : results
  task automatic wait_n(input int n);
    repeat (n) @(posedge ref_clk);
  endtask : wait_n
  initial begin
    wait_n(12);
    rst_n <= 1'b1;
    wait_n(1);
    chk({31'h0, removal_led_out}, 32'h1);
    chk({31'h0, enum_pin}, 32'h1);
    foreach (rows[i]) begin
      bus(rows[i].w, rows[i].a, rows[i].d);
      chk({30'h0, resp}, {30'h0, rows[i].r});
      if (!rows[i].w) chk(got, rows[i].e);
    end
    closed <= 1'b1;
    wait_n(8);
    chk({31'h0, removal_led_out}, 32'h1);
    bus(1'b0, HSSC_CSR_ADDR, 32'h0);
    chk(got, 32'h0);
    bus(1'b0, HSSC_MISC_ADDR, 32'h0);
    chk(got, 32'h100);
    bus(1'b1, HSSC_PRE_ADDR, 32'h1);
    wait_n(8);
    chk({31'h0, removal_led_out}, 32'h0);
    bus(1'b1, HSSC_CSR_ADDR, 32'h8);
    wait_n(4);
    chk({31'h0, removal_led_out}, 32'h1);
    bus(1'b1, HSSC_CSR_ADDR, 32'h0);
    closed <= 1'b0;
    wait_n(8);
    chk({30'h0, removal_led_out, enum_pin}, 32'h0);
    chk({31'h0, irq_out}, 32'h1);
    bus(1'b0, HSSC_CSR_ADDR, 32'h0);
    chk(got, 32'h40);
    bus(1'b1, HSSC_CSR_ADDR, 32'h2);
    wait_n(4);
    chk({31'h0, enum_pin}, 32'h1);
    bus(1'b1, HSSC_CSR_ADDR, 32'h0);
    closed <= 1'b1;
    wait_n(8);
    chk({31'h0, enum_pin}, 32'h0);
    bus(1'b0, HSSC_CSR_ADDR, 32'h0);
    chk(got, 32'hC0);
    bus(1'b1, HSSC_CSR_ADDR, 32'hC0);
    bus(1'b1, HSSC_MASK_ADDR, 32'h0);
    wait_n(4);
    chk({30'h0, enum_pin, irq_out}, 32'h2);
    bus(1'b1, HSSC_IRQ_ADDR, 32'h3);
    bus(1'b1, HSSC_MASK_ADDR, 32'h3);
    wait_n(4);
    chk({31'h0, irq_out}, 32'h0);
    // Byte lane 0 disabled: write must be ignored but answered OKAY
    s_axi_wstrb <= 4'h0;
    bus(1'b1, HSSC_CSR_ADDR, 32'h8);
    chk({30'h0, resp}, {30'h0, HSSC_RESP_OK});
    s_axi_wstrb <= 4'hF;
    wait_n(4);
    chk({31'h0, removal_led_out}, 32'h0);
    // Second reset with the handle closed: LED held until preload again
    rst_n <= 1'b0;
    wait_n(2);
    rst_n <= 1'b1;
    wait_n(1);
    chk({31'h0, removal_led_out}, 32'h1);
    wait_n(8);
    chk({31'h0, removal_led_out}, 32'h1);
    bus(1'b1, HSSC_PRE_ADDR, 32'h1);
    wait_n(8);
    chk({31'h0, removal_led_out}, 32'h0);
    bus(1'b0, HSSC_CSR_ADDR, 32'h0);
    chk(got, 32'h0);
    results();
  end
  initial begin
    wait_n(3000);
    bad_count++;
    results();
  end
endmodule : hssc_top_tb
`default_nettype wire
